// File: rtl/motor_current_protection.sv
// Our own choices: the register addresses and strobed register access.
`timescale 1ns/100ps
module motor_current_protection #(
   parameter logic [15:0] DEVICE_RATED_CURRENT = 16'h0064,
   parameter int          TICK_CYCLES          = motor_prot_pkg::TICK_CYC
) (
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        rstn,
   // register port
   input  wire logic [3:0]  regAddr,
   input  wire logic [15:0] regWdata,
   input  wire logic        regWr,
   input  wire logic        regRd,
   output logic      [15:0] regRdata,
   // motor side
   input  wire logic [15:0] motorCurrent,
   input  wire logic [3:0]  motorState,
   input  wire logic        set2Input,
   // outputs
   output logic             useSecondSet,
   output logic             trip,
   output logic      [7:0]  faultCode,
   output logic             irq
);
   // ---------------------------------------------------------------
   // input synchroniser and tick
   // ---------------------------------------------------------------
   logic        pinMeta_r;
   logic        pinSync_r;
   logic [31:0] tickCnt_r;
   logic [31:0] tickCnt_nxt;
   logic        tick;

   always_comb begin
      tickCnt_nxt = tickCnt_r + 32'h1;
      if (tickCnt_r == 32'(TICK_CYCLES - 1)) begin
         tickCnt_nxt = 32'h0;
      end
   end
   assign tick = (tickCnt_r == 32'(TICK_CYCLES - 1));

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         pinMeta_r <= 1'b0;
         pinSync_r <= 1'b0;
         tickCnt_r <= 32'h0;
      end else begin
         pinMeta_r <= set2Input;
         pinSync_r <= pinMeta_r;
         tickCnt_r <= tickCnt_nxt;
      end
   end

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   localparam logic [15:0] RATED_MIN =
      16'((32'(DEVICE_RATED_CURRENT) * 32'd4) / 32'd10);
   localparam logic [15:0] ILIM_CAP = motor_prot_pkg::ILIM_DEF;

   logic [2:0]  ctrl_r,   ctrl_nxt;
   // second set and protection settings, one word per address
   localparam logic [3:0] PAR_LO = motor_prot_pkg::ADDR_INITV;
   localparam logic [3:0] PAR_HI = motor_prot_pkg::ADDR_OCDLY;
   logic [15:0] param_r   [PAR_LO:PAR_HI];
   logic [15:0] param_nxt [PAR_LO:PAR_HI];
   logic [2:0]  status_r, status_nxt;
   logic [2:0]  irqEn_r,  irqEn_nxt;
   logic [7:0]  fault_r,  fault_nxt;
   logic [15:0] rdata_r,  rdata_nxt;
   logic        adv;
   logic        stopped;
   logic        running;
   logic        wrOk;
   logic        ucExp;
   logic        ocExp;
   logic [2:0]  events;

   assign adv     = ctrl_r[motor_prot_pkg::CTRL_ADV];
   assign stopped = (motorState == motor_prot_pkg::ST_IDLE);
   assign running = (motorState == motor_prot_pkg::ST_RUN);

   always_comb begin
      ctrl_nxt   = ctrl_r;
      param_nxt  = param_r;
      irqEn_nxt  = irqEn_r;
      wrOk       = 1'b1;
      if (regWr) begin
         if (regAddr == motor_prot_pkg::ADDR_CTRL) begin
            ctrl_nxt = regWdata[2:0];
         end else if (regAddr == motor_prot_pkg::ADDR_IRQEN) begin
            irqEn_nxt = regWdata[2:0];
         end else if (regAddr == motor_prot_pkg::ADDR_IRQCLR ||
                      regAddr == motor_prot_pkg::ADDR_STATUS ||
                      regAddr == motor_prot_pkg::ADDR_FAULT) begin
            wrOk = 1'b1;
         end else if (!adv) begin
            wrOk = 1'b0;
         end else if (regAddr == motor_prot_pkg::ADDR_INITV) begin
            wrOk = regWdata >= motor_prot_pkg::INITV_MIN &&
                   regWdata <= motor_prot_pkg::INITV_MAX;
         end else if (regAddr == motor_prot_pkg::ADDR_ILIM) begin
            wrOk = regWdata >= motor_prot_pkg::ILIM_MIN &&
                   regWdata <= motor_prot_pkg::ILIM_MAX &&
                   regWdata <= ILIM_CAP;
         end else if (regAddr == motor_prot_pkg::ADDR_ACCEL) begin
            wrOk = regWdata >= motor_prot_pkg::ACCEL_MIN &&
                   regWdata <= motor_prot_pkg::ACCEL_MAX;
         end else if (regAddr == motor_prot_pkg::ADDR_DECEL) begin
            wrOk = regWdata <= motor_prot_pkg::DECEL_MAX;
         end else if (regAddr == motor_prot_pkg::ADDR_RATED) begin
            wrOk = stopped && regWdata >= RATED_MIN &&
                   regWdata <= DEVICE_RATED_CURRENT;
         end else if (regAddr == motor_prot_pkg::ADDR_UCTH) begin
            wrOk = regWdata == motor_prot_pkg::UCTH_OFF ||
                   (regWdata >= motor_prot_pkg::UCTH_MIN &&
                    regWdata <= motor_prot_pkg::UCTH_MAX);
         end else if (regAddr == motor_prot_pkg::ADDR_UCDLY) begin
            wrOk = regWdata >= motor_prot_pkg::UCDLY_MIN &&
                   regWdata <= motor_prot_pkg::UCDLY_MAX;
         end else if (regAddr == motor_prot_pkg::ADDR_OCTH) begin
            wrOk = regWdata >= motor_prot_pkg::OCTH_MIN &&
                   regWdata <= motor_prot_pkg::OCTH_MAX &&
                   (regWdata % motor_prot_pkg::OCTH_STEP) == 16'h0;
         end else if (regAddr == motor_prot_pkg::ADDR_OCDLY) begin
            wrOk = regWdata <= motor_prot_pkg::OCDLY_MAX;
         end else begin
            wrOk = 1'b0;
         end
      end
      if (regWr && wrOk && regAddr >= PAR_LO && regAddr <= PAR_HI) begin
         param_nxt[regAddr] = regWdata;
      end
   end

   // ---------------------------------------------------------------
   // protection timers
   // ---------------------------------------------------------------
   logic [31:0] ucLimit;
   logic [31:0] ocLimit;
   logic [31:0] curScaled;
   logic [15:0] ucTicks;
   logic [15:0] rated, ucTh, ucDly, ocTh, ocDly;
   logic        ucLow;
   logic        ocHigh;

   assign rated     = param_r[motor_prot_pkg::ADDR_RATED];
   assign ucTh      = param_r[motor_prot_pkg::ADDR_UCTH];
   assign ucDly     = param_r[motor_prot_pkg::ADDR_UCDLY];
   assign ocTh      = param_r[motor_prot_pkg::ADDR_OCTH];
   assign ocDly     = param_r[motor_prot_pkg::ADDR_OCDLY];
   assign curScaled = 32'(motorCurrent) * 32'(motor_prot_pkg::PCT_FULL);
   assign ucLimit   = 32'(rated) * 32'(ucTh);
   assign ocLimit   = 32'(rated) * 32'(ocTh);
   assign ucLow     = (ucTh != motor_prot_pkg::UCTH_OFF) &&
                      (curScaled < ucLimit);
   assign ocHigh    = curScaled > ocLimit;
   assign ucTicks   = 16'(32'(ucDly) * motor_prot_pkg::TICKS_PER_S);

   limit_timer u_ucTimer (
      .mclk       (mclk),
      .rstn       (rstn),
      .enable     (running && adv),
      .excursion  (ucLow),
      .tick       (tick),
      .delayTicks (ucTicks),
      .expired    (ucExp)
   );

   limit_timer u_ocTimer (
      .mclk       (mclk),
      .rstn       (rstn),
      .enable     (running && adv),
      .excursion  (ocHigh),
      .tick       (tick),
      .delayTicks (ocDly),
      .expired    (ocExp)
   );

   // ---------------------------------------------------------------
   // faults, status and read-back
   // ---------------------------------------------------------------
   assign events = {regWr && !wrOk, ocExp, ucExp};

   always_comb begin
      fault_nxt = fault_r;
      if (fault_r == motor_prot_pkg::FAULT_NONE) begin
         if (ocExp) begin
            fault_nxt = motor_prot_pkg::OVERCURRENT_FAULT_CODE;
         end else if (ucExp) begin
            fault_nxt = motor_prot_pkg::UNDERCURRENT_FAULT_CODE;
         end
      end else if (regWr && regAddr == motor_prot_pkg::ADDR_FAULT) begin
         fault_nxt = motor_prot_pkg::FAULT_NONE;
      end
      status_nxt = status_r;
      if (regWr && regAddr == motor_prot_pkg::ADDR_IRQCLR) begin
         status_nxt = status_r & ~regWdata[2:0];
      end
      status_nxt = status_nxt | events;
      rdata_nxt = 16'h0000;
      if (regRd) begin
         if (regAddr == motor_prot_pkg::ADDR_CTRL) begin
            rdata_nxt = {13'h0, ctrl_r};
         end else if (regAddr == motor_prot_pkg::ADDR_STATUS) begin
            rdata_nxt = {13'h0, status_r};
         end else if (regAddr == motor_prot_pkg::ADDR_IRQEN) begin
            rdata_nxt = {13'h0, irqEn_r};
         end else if (regAddr == motor_prot_pkg::ADDR_FAULT) begin
            rdata_nxt = {8'h0, fault_r};
         end else if (!adv) begin
            rdata_nxt = 16'h0000;
         end else if (regAddr >= PAR_LO && regAddr <= PAR_HI) begin
            rdata_nxt = param_r[regAddr];
         end
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         ctrl_r   <= 3'h0;
         param_r[motor_prot_pkg::ADDR_INITV] <= motor_prot_pkg::INITV_DEF;
         param_r[motor_prot_pkg::ADDR_ILIM]  <= motor_prot_pkg::ILIM_DEF;
         param_r[motor_prot_pkg::ADDR_ACCEL] <= motor_prot_pkg::ACCEL_DEF;
         param_r[motor_prot_pkg::ADDR_DECEL] <= motor_prot_pkg::DECEL_FREE;
         param_r[motor_prot_pkg::ADDR_RATED] <= DEVICE_RATED_CURRENT;
         param_r[motor_prot_pkg::ADDR_UCTH]  <= motor_prot_pkg::UCTH_OFF;
         param_r[motor_prot_pkg::ADDR_UCDLY] <= motor_prot_pkg::UCDLY_DEF;
         param_r[motor_prot_pkg::ADDR_OCTH]  <= motor_prot_pkg::OCTH_DEF;
         param_r[motor_prot_pkg::ADDR_OCDLY] <= motor_prot_pkg::OCDLY_DEF;
         status_r <= 3'h0;
         irqEn_r  <= 3'h0;
         fault_r  <= motor_prot_pkg::FAULT_NONE;
         rdata_r  <= 16'h0000;
      end else begin
         ctrl_r   <= ctrl_nxt;
         param_r  <= param_nxt;
         status_r <= status_nxt;
         irqEn_r  <= irqEn_nxt;
         fault_r  <= fault_nxt;
         rdata_r  <= rdata_nxt;
      end
   end

   assign regRdata  = rdata_r;
   assign faultCode = fault_r;
   assign trip      = (fault_r != motor_prot_pkg::FAULT_NONE);
   assign irq       = |(status_r & irqEn_r);
   assign useSecondSet = adv && (ctrl_r[motor_prot_pkg::CTRL_SEL2] ||
      (ctrl_r[motor_prot_pkg::CTRL_INSEL] && pinSync_r));

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   property p_rated_stop;
      @(posedge mclk) disable iff (!rstn)
      (regWr && regAddr == motor_prot_pkg::ADDR_RATED && !stopped)
         |=> $stable(rated);
   endproperty
   a_rated_stop: assert property (p_rated_stop)
      else $error("rated current written while not stopped");
   property p_adv_lock;
      @(posedge mclk) disable iff (!rstn)
      (regWr && !adv && regAddr == motor_prot_pkg::ADDR_ACCEL)
         |=> $stable(param_r[motor_prot_pkg::ADDR_ACCEL]);
   endproperty
   a_adv_lock: assert property (p_adv_lock)
      else $error("second set written outside advanced mode");
   property p_idle_notrip;
      @(posedge mclk) disable iff (!rstn)
      !running |-> !ucExp && !ocExp;
   endproperty
   a_idle_notrip: assert property (p_idle_notrip)
      else $error("protection active outside running");
   property p_oc_code;
      @(posedge mclk) disable iff (!rstn)
      (ocExp && !trip) |=> faultCode == motor_prot_pkg::OVERCURRENT_FAULT_CODE;
   endproperty
   a_oc_code: assert property (p_oc_code)
      else $error("over-current code missing");
   property p_uc_code;
      @(posedge mclk) disable iff (!rstn)
      (ucExp && !ocExp && !trip)
         |=> faultCode == motor_prot_pkg::UNDERCURRENT_FAULT_CODE;
   endproperty
   a_uc_code: assert property (p_uc_code)
      else $error("under-current code missing");
   property p_uc_off;
      @(posedge mclk) disable iff (!rstn)
      (ucTh == motor_prot_pkg::UCTH_OFF) |-> !ucExp;
   endproperty
   a_uc_off: assert property (p_uc_off)
      else $error("under-current trips while off");
   property p_ocdly_range;
      @(posedge mclk) disable iff (!rstn)
      ocDly <= motor_prot_pkg::OCDLY_MAX;
   endproperty
   a_ocdly_range: assert property (p_ocdly_range)
      else $error("over-current delay out of range");
   property p_initv_range;
      @(posedge mclk) disable iff (!rstn)
      param_r[motor_prot_pkg::ADDR_INITV] >= motor_prot_pkg::INITV_MIN &&
      param_r[motor_prot_pkg::ADDR_INITV] <= motor_prot_pkg::INITV_MAX;
   endproperty
   a_initv_range: assert property (p_initv_range)
      else $error("initial voltage out of range");
   property p_sel;
      @(posedge mclk) disable iff (!rstn)
      (adv && ctrl_r[motor_prot_pkg::CTRL_SEL2]) |-> useSecondSet;
   endproperty
   a_sel: assert property (p_sel)
      else $error("second set not selected");
endmodule

// File: rtl/motor_prot_pkg.sv
package motor_prot_pkg;
   // ---------------------------------------------------------------
   // register offsets
   // ---------------------------------------------------------------
   localparam logic [3:0] ADDR_CTRL     = 4'h0;
   localparam logic [3:0] ADDR_INITV    = 4'h1;
   localparam logic [3:0] ADDR_ILIM     = 4'h2;
   localparam logic [3:0] ADDR_ACCEL    = 4'h3;
   localparam logic [3:0] ADDR_DECEL    = 4'h4;
   localparam logic [3:0] ADDR_RATED    = 4'h5;
   localparam logic [3:0] ADDR_UCTH     = 4'h6;
   localparam logic [3:0] ADDR_UCDLY    = 4'h7;
   localparam logic [3:0] ADDR_OCTH     = 4'h8;
   localparam logic [3:0] ADDR_OCDLY    = 4'h9;
   localparam logic [3:0] ADDR_STATUS   = 4'ha;
   localparam logic [3:0] ADDR_IRQEN    = 4'hb;
   localparam logic [3:0] ADDR_IRQCLR   = 4'hc;
   localparam logic [3:0] ADDR_FAULT    = 4'hd;
   // ---------------------------------------------------------------
   // control bits
   // ---------------------------------------------------------------
   localparam int CTRL_ADV    = 0;
   localparam int CTRL_SEL2   = 1;
   localparam int CTRL_INSEL  = 2;
   // ---------------------------------------------------------------
   // ranges and defaults
   // ---------------------------------------------------------------
   localparam logic [15:0] INITV_MIN  = 16'h000a;
   localparam logic [15:0] INITV_MAX  = 16'h0032;
   localparam logic [15:0] INITV_DEF  = 16'h001e;
   localparam logic [15:0] ILIM_MIN   = 16'h00c8;
   localparam logic [15:0] ILIM_MAX   = 16'h02bc;
   localparam logic [15:0] ILIM_DEF   = 16'h015e;
   localparam logic [15:0] ACCEL_MIN  = 16'h0001;
   localparam logic [15:0] ACCEL_MAX  = 16'h003c;
   localparam logic [15:0] ACCEL_DEF  = 16'h000a;
   localparam logic [15:0] DECEL_FREE = 16'h0000;
   localparam logic [15:0] DECEL_MAX  = 16'h003c;
   localparam logic [15:0] UCTH_OFF   = 16'h0000;
   localparam logic [15:0] UCTH_MIN   = 16'h0014;
   localparam logic [15:0] UCTH_MAX   = 16'h005a;
   localparam logic [15:0] UCDLY_MIN  = 16'h0001;
   localparam logic [15:0] UCDLY_MAX  = 16'h0028;
   localparam logic [15:0] UCDLY_DEF  = 16'h000a;
   localparam logic [15:0] OCTH_MIN   = 16'h0064;
   localparam logic [15:0] OCTH_MAX   = 16'h012c;
   localparam logic [15:0] OCTH_STEP  = 16'h0005;
   localparam logic [15:0] OCTH_DEF   = 16'h00c8;
   localparam logic [15:0] OCDLY_MAX  = 16'h0032;
   localparam logic [15:0] OCDLY_DEF  = 16'h0005;
   localparam logic [15:0] PCT_FULL   = 16'h0064;
   // ---------------------------------------------------------------
   // fault codes and events
   // ---------------------------------------------------------------
   localparam logic [7:0] FAULT_NONE             = 8'h00;
   localparam logic [7:0] UNDERCURRENT_FAULT_CODE = 8'h01;
   localparam logic [7:0] OVERCURRENT_FAULT_CODE  = 8'h02;
   localparam int EV_UC  = 0;
   localparam int EV_OC  = 1;
   localparam int EV_REJ = 2;
   localparam int NEV    = 3;
   // ---------------------------------------------------------------
   // timing: 125 MHz clock, tick at 0.1 s
   // ---------------------------------------------------------------
   localparam int CLK_HZ     = 125000000;
   localparam int TICK_MS    = 100;
   localparam int TICK_CYC   = CLK_HZ / 1000 * TICK_MS;
   localparam int TICKS_PER_S = 10;
   typedef enum logic [3:0] {
      ST_IDLE  = 4'b0001,
      ST_START = 4'b0010,
      ST_RUN   = 4'b0100,
      ST_STOP  = 4'b1000
   } motor_state_e;
endpackage

// File: rtl/limit_timer.sv
`timescale 1ns/100ps
module limit_timer (
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        rstn,
   // control
   input  wire logic        enable,
   input  wire logic        excursion,
   input  wire logic        tick,
   input  wire logic [15:0] delayTicks,
   // result
   output logic             expired
);
   logic [15:0] count_r;
   logic [15:0] count_nxt;

   always_comb begin
      count_nxt = count_r;
      if (!enable || !excursion) begin
         count_nxt = 16'h0000;
      end else if (tick && count_r <= delayTicks) begin
         count_nxt = count_r + 16'h0001;
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         count_r <= 16'h0000;
      end else begin
         count_r <= count_nxt;
      end
   end

   // trips only after the delay has been fully exceeded
   assign expired = enable && excursion && (count_r > delayTicks);

   property p_hold_clear;
      @(posedge mclk) disable iff (!rstn)
      !enable |=> count_r == 16'h0000;
   endproperty
   a_hold_clear: assert property (p_hold_clear)
      else $error("delay timer not cleared outside running");
   property p_restart;
      @(posedge mclk) disable iff (!rstn)
      !excursion |=> count_r == 16'h0000;
   endproperty
   a_restart: assert property (p_restart)
      else $error("delay timer kept counting inside the limit");
endmodule

// File: dv/motor_model.sv
`timescale 1ns/100ps
module motor_model (
   // clock
   input  wire logic        mclk,
   // commands from the bench
   input  wire logic [3:0]  stateCmd,
   input  wire logic [15:0] loadCmd,
   input  wire logic        pinCmd,
   // motor and input terminal
   output logic      [3:0]  motorState,
   output logic      [15:0] motorCurrent,
   output logic             set2Input
);
   initial begin
      motorState   = 4'h1;
      motorCurrent = 16'h0000;
      set2Input    = 1'b0;
   end
   // a stopped motor draws no current
   always @(posedge mclk) begin
      motorState   <= stateCmd;
      motorCurrent <= (stateCmd == 4'h1) ? 16'h0000 : loadCmd;
      set2Input    <= pinCmd;
   end
endmodule

// File: dv/test_motor_current_protection.sv
`timescale 1ns/100ps
module test_motor_current_protection;
   logic mclk = 1'b0, rstn = 1'b0, regWr = 1'b0, regRd = 1'b0, pinCmd = 1'b0;
   logic [3:0] regAddr = 4'h0, stateCmd = 4'h1, motorState;
   logic [15:0] regWdata = 16'h0000, loadCmd = 16'h0000, regRdata;
   logic [15:0] motorCurrent, v;
   logic set2Input, useSecondSet, trip, irq;
   logic [7:0] faultCode;
   int errors = 0, checks = 0, cyc = 0;
   logic [19:0] rows [11] = '{20'h1001e, 20'h2015e, 20'h3000a, 20'h40000,
      20'h50064, 20'h60000, 20'h7000a, 20'h800c8, 20'h90005, 20'hd0000,
      20'he0000};
   always #4 mclk = ~mclk;
   motor_current_protection #(.TICK_CYCLES(4)) u_motor_current_protection (
      .mclk(mclk), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata),
      .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
      .motorCurrent(motorCurrent), .motorState(motorState),
      .set2Input(set2Input), .useSecondSet(useSecondSet), .trip(trip),
      .faultCode(faultCode), .irq(irq));
   motor_model u_motor_model (
      .mclk(mclk), .stateCmd(stateCmd), .loadCmd(loadCmd), .pinCmd(pinCmd),
      .motorState(motorState), .motorCurrent(motorCurrent),
      .set2Input(set2Input));
   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   task automatic finish_test();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc > 20000) begin
         errors++;
         finish_test();
      end
   end
   task automatic chk(string name, logic [15:0] seen, logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic wr(logic [3:0] a, logic [15:0] d);
      @(posedge mclk);
      regWr    <= 1'b1;
      regAddr  <= a;
      regWdata <= d;
      @(posedge mclk);
      regWr    <= 1'b0;
   endtask
   task automatic rd(logic [3:0] a, output logic [15:0] d);
      @(posedge mclk);
      regRd   <= 1'b1;
      regAddr <= a;
      @(posedge mclk);
      regRd   <= 1'b0;
      #1 d = regRdata;
   endtask
   task automatic wait_trip(int n);
      for (int i = 0; i < n && trip !== 1'b1; i++) begin
         @(posedge mclk);
         #1;
      end
   endtask
   task automatic idle_cycles(int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   // ---------------------------------------------------------------
   // sequence
   // ---------------------------------------------------------------
   initial begin
      repeat (4) @(posedge mclk);
      rstn <= 1'b1;
      rd(4'h1, v);
      chk("initv locked", v, 16'h0000);
      wr(4'h0, 16'h0001);
      for (int i = 0; i < 11; i++) begin
         rd(rows[i][19:16], v);
         chk("default", v, rows[i][15:0]);
      end
      $display("defaults done");
      wr(4'h1, 16'h0009);
      rd(4'h1, v);
      chk("initv low", v, 16'h001e);
      rd(4'ha, v);
      chk("refused flag", v, 16'h0004);
      wr(4'h1, 16'h0032);
      rd(4'h1, v);
      chk("initv max", v, 16'h0032);
      wr(4'h2, 16'h015f);
      rd(4'h2, v);
      chk("ilim high", v, 16'h015e);
      wr(4'h3, 16'h003d);
      rd(4'h3, v);
      chk("accel high", v, 16'h000a);
      wr(4'h4, 16'h003c);
      rd(4'h4, v);
      chk("decel max", v, 16'h003c);
      wr(4'h9, 16'h0033);
      rd(4'h9, v);
      chk("ocdly high", v, 16'h0005);
      wr(4'h0, 16'h0000);
      wr(4'h1, 16'h0014);
      wr(4'h0, 16'h0001);
      rd(4'h1, v);
      chk("locked write", v, 16'h0032);
      $display("ranges done");
      wr(4'h0, 16'h0003);
      idle_cycles(1);
      chk("link select", useSecondSet, 1'b1);
      wr(4'h0, 16'h0005);
      idle_cycles(4);
      chk("pin low", useSecondSet, 1'b0);
      pinCmd <= 1'b1;
      idle_cycles(6);
      chk("pin select", useSecondSet, 1'b1);
      wr(4'h0, 16'h0001);
      pinCmd <= 1'b0;
      $display("select done");
      wr(4'hb, 16'h0003);
      wr(4'hc, 16'h0007);
      stateCmd <= 4'h4;
      loadCmd <= 16'h0064;
      wr(4'h5, 16'h0032);
      rd(4'h5, v);
      chk("rated running", v, 16'h0064);
      stateCmd <= 4'h1;
      wr(4'h5, 16'h0027);
      rd(4'h5, v);
      chk("rated low", v, 16'h0064);
      wr(4'h5, 16'h0028);
      rd(4'h5, v);
      chk("rated min", v, 16'h0028);
      wr(4'h5, 16'h0064);
      wr(4'hc, 16'h0007);
      $display("rated done");
      stateCmd <= 4'h2;
      loadCmd <= 16'h00fa;
      idle_cycles(60);
      chk("start no trip", trip, 1'b0);
      stateCmd <= 4'h4;
      idle_cycles(16);
      loadCmd <= 16'h0064;
      idle_cycles(8);
      loadCmd <= 16'h00fa;
      idle_cycles(16);
      loadCmd <= 16'h0064;
      idle_cycles(2);
      chk("restart", trip, 1'b0);
      loadCmd <= 16'h00fa;
      idle_cycles(16);
      chk("oc early", trip, 1'b0);
      wait_trip(40);
      chk("oc trip", trip, 1'b1);
      chk("oc code", faultCode, 8'h02);
      chk("oc irq", irq, 1'b1);
      rd(4'ha, v);
      chk("oc status", v, 16'h0002);
      stateCmd <= 4'h1;
      wr(4'hc, 16'h0007);
      wr(4'hd, 16'h0000);
      idle_cycles(1);
      chk("cleared", {trip, irq}, 2'b00);
      $display("overcurrent done");
      wr(4'h6, 16'h0032);
      wr(4'h7, 16'h0001);
      stateCmd <= 4'h4;
      loadCmd <= 16'h001e;
      idle_cycles(30);
      chk("uc early", trip, 1'b0);
      wait_trip(80);
      chk("uc trip", trip, 1'b1);
      chk("uc code", faultCode, 8'h01);
      $display("undercurrent done");
      rstn <= 1'b0;
      idle_cycles(2);
      chk("reset outputs", {faultCode, trip, irq, useSecondSet}, 11'h000);
      rstn <= 1'b1;
      rd(4'h7, v);
      chk("reset locked", v, 16'h0000);
      wr(4'h0, 16'h0001);
      rd(4'h7, v);
      chk("reset default", v, 16'h000a);
      $display("reset done");
      finish_test();
   end
endmodule
